/* rtl/ttam_top.sv */
// module: two-track train presence and alarm contact monitor
`timescale 1ns/1ps
module ttam_top #(
  parameter int MS_CYCLES = ttam_pkg::MS_CYCLES_DEF
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [1:0] TRANSDUCER_I,
  input wire logic [1:0] PRESENCE_CONTACT_I,
  input wire logic [7:0] ALARM_CONTACT_I,
  input wire logic [3:0] ACTIVATION_MODE_I,
  input wire logic [31:0] INPUT_TYPE_I,
  input wire logic [7:0] MAX_ALARMS_I,
  input wire logic [15:0] ADVANCE_TIME_S_I,
  input wire logic [15:0] ALARM_INTERVAL_S_I,
  input wire logic [15:0] ALARM_DURATION_S_I,
  input wire logic DEFECTS_ONLY_I,
  input wire logic ANN_READY_I,
  output logic ANN_VALID_O,
  output logic [3:0] ANN_KIND_O,
  output logic ANN_TRACK_O,
  output logic [1:0] ANN_INPUT_O,
  output logic [3:0] ANN_ALARM_TYPE_O,
  output logic [11:0] ANN_AXLE_O,
  output logic ANN_MULTI_O,
  output logic [1:0] TRACK_ACTIVE_O,
  output logic [7:0] MALFUNCTION_O
);
  logic [11:0] syn;
  logic [31:0] ms_div;
  logic ms_tick;
  logic [9:0] ms_cnt;
  logic sec_tick;
  logic [2:0] slot;
  logic [3:0] wp;
  logic [3:0] rp;
  logic [4:0] q_cnt;
  logic q_full;
  logic q_wr;
  logic q_pop;
  logic [1:0] trk_wr;
  ttam_pkg::ttam_ev_type trk_ev [2];
  logic [1:0] trk_act;
  logic [7:0] trk_malf;
  ttam_pkg::ttam_ev_type head;

  // R23 contact and transducer inputs synchronised
  ttam_sync #(.N(12)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .d_i({ALARM_CONTACT_I, PRESENCE_CONTACT_I, TRANSDUCER_I}),
    .q_o(syn)
  );

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
    end else if (ms_div == 32'(MS_CYCLES - 1)) begin
      ms_div <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_div <= ms_div + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ms_cnt <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (ms_tick) begin
        if (ms_cnt == 10'(ttam_pkg::MS_PER_S - 1)) begin
          ms_cnt <= '0;
          sec_tick <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 10'h1;
        end
      end
    end
  end

  // each track owns four cycles of eight, one per alarm input
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      slot <= '0;
    end else begin
      slot <= slot + 3'h1;
    end
  end

  for (genvar t = 0; t < ttam_pkg::N_TRK; t++) begin : g_trk
    logic [1:0] mode;
    logic trans;
    logic appr;
    logic cont;
    logic tdx;
    logic tdx_d;
    logic pres;
    logic [3:0] closed;
    logic go;
    logic [1:0] idx;
    logic [15:0] cfg;
    logic [3:0] ty;
    logic [3:0] max;
    logic [17:0] adv_ms;
    logic [7:0] ivl;
    logic [7:0] dur;
    ttam_pkg::ttam_state_type st;
    logic [11:0] axle;
    logic [13:0] gap_ms;
    logic pulse_pend;
    logic [4:0] nalm;
    logic [4:0] nrec;
    logic [4:0] rep_idx;
    logic rd_ph;
    logic mrep;
    logic [3:0] armed;
    logic [3:0] rearm;
    logic [3:0] malf;
    logic [3:0] pre_pend;
    logic [3:0] cact;
    logic [3:0] rep_due;
    logic [1:0] dax [4];
    logic [17:0] cms [4];
    logic [7:0] csec [4];
    logic [7:0] isec [4];
    ttam_pkg::ttam_ev_type ev;
    logic a_start, a_end, a_pulse, a_pre, a_alarm, a_calm, a_crep;
    logic a_rd, a_rep, a_recs, a_mrep, a_sum;

    assign mode = ACTIVATION_MODE_I[2*t +: 2];
    assign trans = mode == ttam_pkg::MODE_TRANSDUCER;
    assign appr = mode == ttam_pkg::MODE_APPROACH;
    assign cont = mode == ttam_pkg::MODE_CONTINUOUS;
    assign tdx = syn[t];
    assign pres = syn[2+t];
    assign closed = syn[4+4*t +: 4];
    assign go = slot[2] == 1'(t) && !q_full;
    assign idx = slot[1:0];
    // R7 four inputs, each with its own type field
    assign cfg = INPUT_TYPE_I[16*t +: 16];
    assign ty = ttam_pkg::type_of(cfg, idx);
    assign max = MAX_ALARMS_I[4*t +: 4];
    assign adv_ms = 18'(ADVANCE_TIME_S_I[8*t +: 8]) * 18'(ttam_pkg::MS_PER_S);
    assign ivl = ALARM_INTERVAL_S_I[8*t +: 8];
    assign dur = ALARM_DURATION_S_I[8*t +: 8];
    assign nrec = (nalm > {1'b0, max}) ? {1'b0, max} : nalm;

    ttam_mem_if #(.W(ttam_pkg::REC_W), .AW(ttam_pkg::REC_AW)) rec_if ();
    // R16 records kept only up to the maximum
    assign rec_if.we = go && a_alarm && nalm < {1'b0, max};
    assign rec_if.waddr = nalm[3:0];
    assign rec_if.wdata = {idx, ty, axle};
    assign rec_if.raddr = rep_idx[3:0];
    ttam_mem u_rec (
      .clk_i(CLK_I),
      .rst_n_i(RESET_N_I),
      .bus(rec_if.mem)
    );

    always_comb begin
      ev = '0;
      ev.track = 1'(t);
      ev.inp = idx;
      ev.atype = ty;
      ev.axle = axle;
      ev.kind = ttam_pkg::EV_NONE;
      {a_start, a_end, a_pulse, a_pre, a_alarm, a_calm, a_crep} = '0;
      {a_rd, a_rep, a_recs, a_mrep, a_sum} = '0;
      unique case (st)
        ttam_pkg::ST_IDLE: begin
          // R1 R5 arrival by first pulse or closed presence contact
          if ((trans && pulse_pend) || (appr && pres)) begin
            a_start = 1'b1;
          // R6 R20 continuous scan takes all ten types
          end else if (cont && ttam_pkg::is_cont_type(ty)) begin
            if (!closed[idx] && armed[idx]) begin
              a_calm = 1'b1;
              ev.kind = ttam_pkg::EV_CONT_ALARM;
            // R19 repeat, malfunction once duration has passed
            end else if (cact[idx] && rep_due[idx]) begin
              a_crep = 1'b1;
              ev.kind = (csec[idx] >= dur) ? ttam_pkg::EV_CONT_MALF : ttam_pkg::EV_CONT_ALARM;
            end
          end
        end
        ttam_pkg::ST_ACTIVE: begin
          // R3 R5 end of train
          if ((trans && gap_ms > ttam_pkg::END_GAP_MS) || (appr && !pres) || !(trans || appr)) begin
            a_end = 1'b1;
          end else if (trans && pulse_pend) begin
            a_pulse = 1'b1;
          // R21 pre-train alarm for an input found active
          end else if (pre_pend[idx]) begin
            a_pre = 1'b1;
            ev.kind = ttam_pkg::EV_PRETRAIN;
          // R8 R9 R13 one alarm per opening, first with message
          end else if (ttam_pkg::is_train_type(ty) && !malf[idx] && !closed[idx] && armed[idx]) begin
            a_alarm = 1'b1;
            ev.kind = (nalm == 5'h00) ? ttam_pkg::EV_DEFECT_TONE : ttam_pkg::EV_TONE;
          end
        end
        ttam_pkg::ST_REPORT: begin
          // R15 stored alarms replayed in order
          if (rep_idx >= nrec) begin
            a_recs = 1'b1;
          end else if (!rd_ph) begin
            a_rd = 1'b1;
          end else begin
            a_rep = 1'b1;
            ev.kind = ttam_pkg::EV_RECORD;
            {ev.inp, ev.atype, ev.axle} = rec_if.rdata;
          end
        end
        ttam_pkg::ST_SUMMARY: begin
          if (|malf && !mrep) begin
            // R21 malfunction report at end of train
            a_mrep = 1'b1;
            ev.kind = ttam_pkg::EV_MALF_END;
          end else begin
            a_sum = 1'b1;
            // R4 classification by axle count
            if (trans && axle < ttam_pkg::MIN_TEST_AXLES) begin
              ev.kind = ttam_pkg::EV_NONE;
            end else if (trans && axle < ttam_pkg::MIN_VALID_AXLES) begin
              ev.kind = ttam_pkg::EV_TEST_TRAIN;
            // R17 no-defects report unless defects-only
            end else if (nalm == 5'h00) begin
              ev.kind = DEFECTS_ONLY_I ? ttam_pkg::EV_NONE : ttam_pkg::EV_NO_DEFECTS;
            end else begin
              // R15 multiple-defects indication
              ev.multi = nalm > {1'b0, max};
              ev.kind = ttam_pkg::EV_DEFECTS;
            end
          end
        end
      endcase
    end

    assign trk_wr[t] = go && ev.kind != ttam_pkg::EV_NONE;
    assign trk_ev[t] = ev;
    assign trk_act[t] = st != ttam_pkg::ST_IDLE || cont;
    assign trk_malf[4*t +: 4] = malf;

    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        st <= ttam_pkg::ST_IDLE;
        axle <= '0;
        nalm <= '0;
        rep_idx <= '0;
        rd_ph <= 1'b0;
        mrep <= 1'b0;
      end else if (go) begin
        if (a_start) begin
          st <= ttam_pkg::ST_ACTIVE;
          axle <= trans ? 12'h001 : 12'h000;
          nalm <= '0;
          mrep <= 1'b0;
        end
        if (a_end) begin
          st <= ttam_pkg::ST_REPORT;
          rep_idx <= '0;
          rd_ph <= 1'b0;
        end
        // R14 alarms carry the count of the latest axle
        if (a_pulse && axle != 12'hfff) begin
          axle <= axle + 12'h001;
        end
        if (a_alarm && nalm != 5'h1f) begin
          nalm <= nalm + 5'h01;
        end
        // read data needs one slot cycle after the address settles
        if (a_rd) begin
          rd_ph <= 1'b1;
        end
        if (a_rep) begin
          rd_ph <= 1'b0;
          rep_idx <= rep_idx + 5'h01;
        end
        if (a_recs) begin
          st <= ttam_pkg::ST_SUMMARY;
        end
        if (a_mrep) begin
          mrep <= 1'b1;
        end
        if (a_sum) begin
          st <= ttam_pkg::ST_IDLE;
        end
      end
    end

    // R2 R3 gap since last transducer pulse, set wins over consume
    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        tdx_d <= 1'b0;
        pulse_pend <= 1'b0;
        gap_ms <= '0;
      end else begin
        tdx_d <= tdx;
        if (tdx && !tdx_d && trans) begin
          pulse_pend <= 1'b1;
        end else if (go && (a_pulse || a_start) || !trans) begin
          pulse_pend <= 1'b0;
        end
        if (tdx && !tdx_d) begin
          gap_ms <= '0;
        end else if (ms_tick && gap_ms != 14'h3fff) begin
          gap_ms <= gap_ms + 14'h0001;
        end
      end
    end

    always_comb begin
      for (int i = 0; i < ttam_pkg::N_IN; i++) begin
        // R11 R12 50 ms closed, R10 dragging needs three axles
        if (appr || ttam_pkg::type_of(cfg, 2'(i)) == ttam_pkg::AT_HIGH
            || ttam_pkg::type_of(cfg, 2'(i)) == ttam_pkg::AT_WIDE) begin
          rearm[i] = closed[i] && cms[i] >= ttam_pkg::REARM_MS;
        end else if (trans && ttam_pkg::type_of(cfg, 2'(i)) == ttam_pkg::AT_DRAG) begin
          rearm[i] = closed[i] && dax[i] == ttam_pkg::DRAG_REARM_AXLES;
        end else begin
          rearm[i] = closed[i];
        end
      end
    end

    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        armed <= '0;
        for (int i = 0; i < ttam_pkg::N_IN; i++) begin
          cms[i] <= '0;
          dax[i] <= ttam_pkg::DRAG_REARM_AXLES;
        end
      end else begin
        for (int i = 0; i < ttam_pkg::N_IN; i++) begin
          if (!closed[i]) begin
            cms[i] <= '0;
          end else if (ms_tick && cms[i] != 18'h3ffff) begin
            cms[i] <= cms[i] + 18'h00001;
          end
          // R13 cleared on the alarm, set only by a closed contact
          if (rearm[i]) begin
            armed[i] <= 1'b1;
          end else if (go && (a_alarm || a_calm) && idx == 2'(i)) begin
            armed[i] <= 1'b0;
          end
          // R10 axles counted since this input's last alarm
          if (go && a_start) begin
            dax[i] <= ttam_pkg::DRAG_REARM_AXLES;
          end else if (go && a_alarm && idx == 2'(i)) begin
            dax[i] <= 2'h0;
          end else if (go && a_pulse && dax[i] != ttam_pkg::DRAG_REARM_AXLES) begin
            dax[i] <= dax[i] + 2'h1;
          end
        end
      end
    end

    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        malf <= '0;
        pre_pend <= '0;
      end else begin
        for (int i = 0; i < ttam_pkg::N_IN; i++) begin
          // R21 input already open at arrival is inhibited for the train
          if (go && a_start && !closed[i]
              && ttam_pkg::is_train_type(ttam_pkg::type_of(cfg, 2'(i)))) begin
            malf[i] <= 1'b1;
            pre_pend[i] <= 1'b1;
          end else begin
            // R22 cleared after advance time inactive with no train
            if (st == ttam_pkg::ST_IDLE && cms[i] > adv_ms) begin
              malf[i] <= 1'b0;
            end
            if (go && a_pre && idx == 2'(i)) begin
              pre_pend[i] <= 1'b0;
            end
          end
        end
      end
    end

    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        cact <= '0;
        rep_due <= '0;
        for (int i = 0; i < ttam_pkg::N_IN; i++) begin
          csec[i] <= '0;
          isec[i] <= '0;
        end
      end else begin
        for (int i = 0; i < ttam_pkg::N_IN; i++) begin
          if (go && a_calm && idx == 2'(i)) begin
            cact[i] <= 1'b1;
            rep_due[i] <= 1'b0;
            csec[i] <= '0;
            isec[i] <= '0;
          end else if (closed[i] || !cont) begin
            cact[i] <= 1'b0;
            rep_due[i] <= 1'b0;
          end else if (sec_tick && cact[i]) begin
            // R19 interval repeats, duration measured from the opening
            if (csec[i] != 8'hff) begin
              csec[i] <= csec[i] + 8'h01;
            end
            if (isec[i] + 8'h01 >= ivl) begin
              isec[i] <= '0;
              rep_due[i] <= 1'b1;
            end else begin
              isec[i] <= isec[i] + 8'h01;
              if (go && a_crep && idx == 2'(i)) begin
                rep_due[i] <= 1'b0;
              end
            end
          end else if (go && a_crep && idx == 2'(i)) begin
            rep_due[i] <= 1'b0;
          end
        end
      end
    end
  end

  // R18 one queue for both tracks, kept in occurrence order
  ttam_mem_if #(.W(ttam_pkg::EV_W), .AW(ttam_pkg::Q_AW)) q_if ();
  assign q_full = q_cnt == ttam_pkg::Q_DEPTH;
  assign q_wr = |trk_wr;
  assign q_pop = ANN_VALID_O && ANN_READY_I;
  assign q_if.we = q_wr;
  assign q_if.waddr = wp;
  assign q_if.raddr = rp;
  assign q_if.wdata = slot[2] ? trk_ev[1] : trk_ev[0];
  ttam_mem u_queue (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .bus(q_if.mem)
  );

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      wp <= '0;
      rp <= '0;
      q_cnt <= '0;
      ANN_VALID_O <= 1'b0;
    end else begin
      wp <= wp + {3'h0, q_wr};
      rp <= rp + {3'h0, q_pop};
      q_cnt <= q_cnt + {4'h0, q_wr} - {4'h0, q_pop};
      if (q_pop) begin
        ANN_VALID_O <= 1'b0;
      end else if (q_cnt != 5'h00) begin
        ANN_VALID_O <= 1'b1;
      end
    end
  end

  assign head = q_if.rdata;
  assign ANN_KIND_O = head.kind;
  assign ANN_TRACK_O = head.track;
  assign ANN_INPUT_O = head.inp;
  assign ANN_ALARM_TYPE_O = head.atype;
  assign ANN_AXLE_O = head.axle;
  assign ANN_MULTI_O = head.multi;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      TRACK_ACTIVE_O <= '0;
      MALFUNCTION_O <= '0;
    end else begin
      TRACK_ACTIVE_O <= trk_act;
      MALFUNCTION_O <= trk_malf;
    end
  end
endmodule : ttam_top

/* include/ttam_pkg.sv */
// package: constants, types and helpers for the track train alarm monitor
// Functional notes
// R1 - transducer rising edge starts scanning enabled alarms
// R2 - pulses under nine seconds apart keep scanning
// R3 - over nine seconds without pulse ends train
// R4 - axles: four+ valid, two-three test, one dropped
// R5 - approach: scan while contact closed, open ends
// R6 - continuous scan: always active, announce each alarm
// R7 - four alarm inputs, ten types or unused
// R8 - train modes accept only four train types
// R9 - first alarm tone plus message, later tone
// R10 - dragging re-arm: close, reopen, three axles
// R11 - high/wide re-arm after 50 ms closed
// R12 - approach mode: 50 ms closed re-arm always
// R13 - contact held open gives exactly one alarm
// R14 - alarm tagged with current or previous axle
// R15 - post-train report in order, multiple flag
// R16 - store records only up to the maximum
// R17 - no alarms: defects-only suppresses, else report
// R18 - queue all tracks' requests in occurrence order
// R19 - continuous repeats at interval, then malfunction repeats
// R20 - auxiliary types work only in continuous scan
// R21 - input active at arrival: malfunction handling
// R22 - idle input inactive past advance time clears
// R23 - inputs synchronised, two independent track units
package ttam_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int END_GAP_S = 9;
  localparam logic [13:0] END_GAP_MS = 14'(END_GAP_S * MS_PER_S);
  localparam logic [17:0] REARM_MS = 18'h00032;
  localparam logic [1:0] DRAG_REARM_AXLES = 2'h3;
  localparam logic [11:0] MIN_VALID_AXLES = 12'h004;
  localparam logic [11:0] MIN_TEST_AXLES = 12'h002;
  localparam int REC_AW = 4;
  localparam int Q_AW = 4;
  localparam logic [4:0] Q_DEPTH = 5'h10;
  localparam int N_TRK = 2;
  localparam int N_IN = 4;

  localparam logic [3:0] AT_UNUSED = 4'h0;
  localparam logic [3:0] AT_DRAG = 4'h1;
  localparam logic [3:0] AT_HIGH = 4'h2;
  localparam logic [3:0] AT_WIDE = 4'h3;
  localparam logic [3:0] AT_SHIFT = 4'h4;
  localparam logic [3:0] AT_POWER_OFF = 4'ha;

  typedef enum logic [1:0] {
    MODE_TRANSDUCER = 2'h0,
    MODE_APPROACH = 2'h1,
    MODE_CONTINUOUS = 2'h2,
    MODE_OFF = 2'h3
  } ttam_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_REPORT = 2'h2,
    ST_SUMMARY = 2'h3
  } ttam_state_type;

  typedef enum logic [3:0] {
    EV_NONE = 4'h0,
    EV_PRETRAIN = 4'h1,
    EV_DEFECT_TONE = 4'h2,
    EV_TONE = 4'h3,
    EV_RECORD = 4'h4,
    EV_MALF_END = 4'h5,
    EV_DEFECTS = 4'h6,
    EV_TEST_TRAIN = 4'h7,
    EV_NO_DEFECTS = 4'h8,
    EV_CONT_ALARM = 4'h9,
    EV_CONT_MALF = 4'ha
  } ttam_ev_kind_type;

  typedef struct packed {
    ttam_ev_kind_type kind;
    logic track;
    logic [1:0] inp;
    logic [3:0] atype;
    logic [11:0] axle;
    logic multi;
  } ttam_ev_type;

  typedef struct packed {
    logic [1:0] inp;
    logic [3:0] atype;
    logic [11:0] axle;
  } ttam_rec_type;

  localparam int EV_W = $bits(ttam_ev_type);
  localparam int REC_W = $bits(ttam_rec_type);

  function automatic logic is_train_type(input logic [3:0] t);
    return t == AT_DRAG || t == AT_HIGH || t == AT_WIDE || t == AT_SHIFT;
  endfunction : is_train_type

  function automatic logic is_cont_type(input logic [3:0] t);
    return t != AT_UNUSED && t <= AT_POWER_OFF;
  endfunction : is_cont_type

  function automatic logic [3:0] type_of(input logic [15:0] cfg, input logic [1:0] i);
    return cfg[{i, 2'h0} +: 4];
  endfunction : type_of
endpackage : ttam_pkg

/* include/ttam_mem_if.sv */
// interface: write and registered-read port of a small memory
`timescale 1ns/1ps
interface ttam_mem_if #(
  parameter int W = 8,
  parameter int AW = 4
) ();
  logic we;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  modport ctrl (output we, waddr, raddr, wdata, input rdata);
  modport mem (input we, waddr, raddr, wdata, output rdata);
endinterface : ttam_mem_if

/* rtl/ttam_sync.sv */
// module: three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ttam_sync #(
  parameter int N = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] d_i,
  output logic [N-1:0] q_o
);
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;

  // a change is taken only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= (s2 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
    end
  end
endmodule : ttam_sync

/* rtl/ttam_mem.sv */
// module: small memory with registered read data
`timescale 1ns/1ps
module ttam_mem (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ttam_mem_if.mem bus
);
  localparam int W = $bits(bus.wdata);
  localparam int AW = $bits(bus.raddr);
  logic [W-1:0] ram [2**AW];

  // cleared at reset so read data is never undefined
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        ram[i] <= '0;
      end
    end else if (bus.we) begin
      ram[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus.rdata <= '0;
    end else begin
      bus.rdata <= ram[bus.raddr];
    end
  end
endmodule : ttam_mem

/* verification/ttam_trackside.sv */
// trackside model: wheel transducer pulses and dry contacts
`timescale 1ns/1ps
module ttam_trackside (
  input wire logic clk_i,
  output logic [1:0] trans_o,
  output logic [9:0] dry_o
);
  // dry_o[7:0] alarm contacts (1 closed), dry_o[9:8] presence contacts
  initial begin
    trans_o = 2'h0;
    dry_o = 10'h0fb;
  end
  // pulse held 6 cycles so the synchroniser filter sees it
  task automatic axle(input int gap, input int op);
    @(posedge clk_i);
    trans_o[0] <= 1'b1;
    repeat (3) @(posedge clk_i);
    if (op >= 0) dry_o[op] <= 1'b0;
    repeat (3) @(posedge clk_i);
    trans_o[0] <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask : axle
  task automatic set(input int i, input logic v, input int n);
    @(posedge clk_i);
    dry_o[i] <= v;
    repeat (n) @(posedge clk_i);
  endtask : set
endmodule : ttam_trackside

/* verification/ttam_properties.sv */
// checker: port-level properties of the track alarm monitor
`timescale 1ns/1ps
module ttam_checker (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [1:0] PRESENCE_CONTACT_I,
  input wire logic [3:0] ACTIVATION_MODE_I,
  input wire logic ANN_READY_I,
  input wire logic ANN_VALID_O,
  input wire logic [3:0] ANN_KIND_O,
  input wire logic ANN_TRACK_O,
  input wire logic ANN_MULTI_O,
  input wire logic [1:0] TRACK_ACTIVE_O,
  input wire logic [7:0] MALFUNCTION_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence held_s;
    ANN_VALID_O && !ANN_READY_I;
  endsequence
  sequence cont1_s;
    (ACTIVATION_MODE_I[3:2] == 2'h2) [*8];
  endsequence
  sequence appr1_s;
    (ACTIVATION_MODE_I[3:2] == 2'h1 && PRESENCE_CONTACT_I[1]) [*8];
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) !RESET_N_I |=>
    !ANN_VALID_O && TRACK_ACTIVE_O == 2'h0 && MALFUNCTION_O == 8'h00)
    else $error("outputs not cleared by reset");
  event_hold_a: assert property (held_s |=> ANN_VALID_O && $stable(ANN_KIND_O))
    else $error("event changed while stalled");
  event_pop_a: assert property (ANN_VALID_O && ANN_READY_I |=> !ANN_VALID_O)
    else $error("event not popped");
  kind_range_a: assert property (ANN_VALID_O |-> ANN_KIND_O inside {[4'h1:4'ha]})
    else $error("illegal event kind");
  multi_kind_a: assert property (ANN_VALID_O && ANN_MULTI_O |-> ANN_KIND_O == 4'h6)
    else $error("multiple flag on wrong kind");
  cont_kind_a: assert property (ANN_VALID_O && ANN_KIND_O > 4'h8 |->
    ACTIVATION_MODE_I[{ANN_TRACK_O, 1'b0} +: 2] == 2'h2)
    else $error("continuous event outside continuous mode");
  train_kind_a: assert property (ANN_VALID_O && ANN_KIND_O < 4'h9 |->
    ACTIVATION_MODE_I[{ANN_TRACK_O, 1'b0} +: 2] != 2'h2)
    else $error("train event in continuous mode");
  cont_active_a: assert property (cont1_s |-> ##6 TRACK_ACTIVE_O[1])
    else $error("continuous track not active");
  appr_active_a: assert property (appr1_s |-> ##6 TRACK_ACTIVE_O[1])
    else $error("approach track not active");
  malf_clear_a: assert property ($fell(MALFUNCTION_O[0]) |-> !$past(TRACK_ACTIVE_O[0]))
    else $error("malfunction cleared during train");
endmodule : ttam_checker
bind ttam_top ttam_checker u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .PRESENCE_CONTACT_I(PRESENCE_CONTACT_I), .ACTIVATION_MODE_I(ACTIVATION_MODE_I),
  .ANN_READY_I(ANN_READY_I), .ANN_VALID_O(ANN_VALID_O), .ANN_KIND_O(ANN_KIND_O),
  .ANN_TRACK_O(ANN_TRACK_O), .ANN_MULTI_O(ANN_MULTI_O), .TRACK_ACTIVE_O(TRACK_ACTIVE_O),
  .MALFUNCTION_O(MALFUNCTION_O));

/* verification/ttam_top_tb.sv */
// testbench: train, alarm and announcement scenarios
`timescale 1ns/1ps
module ttam_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] mode = 4'h4;
  logic def_only = 1'b0;
  logic rdy = 1'b0;
  logic ann_valid, multi;
  logic [3:0] kind;
  logic [11:0] axle;
  logic [5:0] it;
  logic [7:0] max_al = 8'h41;
  logic [1:0] active, trans;
  logic [7:0] malf;
  logic [9:0] dry;
  logic [22:0] got[$];
  logic [22:0] exp_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 11;
  initial forever #4 clk = ~clk;
  ttam_trackside SIDE (.clk_i(clk), .trans_o(trans), .dry_o(dry));
  ttam_top #(.MS_CYCLES(1)) DUT (.CLK_I(clk), .RESET_N_I(rst_n), .TRANSDUCER_I(trans),
    .PRESENCE_CONTACT_I(dry[9:8]), .ALARM_CONTACT_I(dry[7:0]), .ACTIVATION_MODE_I(mode),
    .INPUT_TYPE_I(32'h0003_0521), .MAX_ALARMS_I(max_al), .ADVANCE_TIME_S_I(16'h0101),
    .ALARM_INTERVAL_S_I(16'h0202), .ALARM_DURATION_S_I(16'h0303), .DEFECTS_ONLY_I(def_only),
    .ANN_READY_I(rdy), .ANN_VALID_O(ann_valid), .ANN_KIND_O(kind), .ANN_TRACK_O(),
    .ANN_INPUT_O(it[5:4]), .ANN_ALARM_TYPE_O(it[3:0]), .ANN_AXLE_O(axle), .ANN_MULTI_O(multi),
    .TRACK_ACTIVE_O(active), .MALFUNCTION_O(malf));
  // axle and multiple flag only mean something on some kinds
  function automatic logic [22:0] key(input logic [3:0] k, input logic [17:0] a, input logic m);
    key = {k, (k > 4'h1 && k < 4'h5) ? a : 18'h00000, k == 4'h6 && m};
  endfunction : key
  function automatic logic [3:0] endk(input int ax, input int nal, input logic d);
    if (ax < 2) endk = 4'h0;
    else if (ax < 4) endk = 4'h7;
    else if (nal > 0) endk = 4'h6;
    else endk = d ? 4'h0 : 4'h8;
  endfunction : endk
  function automatic int gap();
    gap = 40 + ({$random(seed)} % 200);
  endfunction : gap
  always @(posedge clk) rdy <= 1'($random(seed));
  always @(posedge clk) if (ann_valid && rdy) got.push_back(key(kind, {it, axle}, multi));
  task automatic exp(input logic [3:0] k, input logic [17:0] a, input logic m);
    exp_q.push_back(key(k, a, m));
  endtask : exp
  task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_q;
    logic [22:0] e, g;
    while (exp_q.size() + got.size() > 0) begin
      e = exp_q.size() ? exp_q.pop_front() : 23'h7fffff;
      g = got.size() ? got.pop_front() : 23'h7ffffe;
      chk("event", e, g);
    end
  endtask : chk_q
  task automatic settle(input int t);
    int i = 0;
    repeat (20) @(posedge clk);
    while (active[t] && i < 12000) begin
      @(posedge clk);
      i++;
    end
    repeat (200) @(posedge clk);
    chk("active", 23'h0, {22'h0, active[t]});
    chk_q();
  endtask : settle
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #(8 * 100000);
    n_mismatch++;
    complete_run();
  end
  initial begin
    int na[3] = '{1, 2, 4};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (100) @(posedge clk);
    // aux input 2 held open throughout: ignored outside continuous scan
    SIDE.axle(gap(), -1);
    SIDE.axle(40, 0);
    SIDE.set(0, 1'b1, 0);
    SIDE.axle(40, 0);
    SIDE.set(0, 1'b1, 0);
    SIDE.axle(gap(), -1);
    SIDE.set(1, 1'b0, 30);
    SIDE.axle(gap(), -1);
    SIDE.set(1, 1'b1, 0);
    SIDE.axle(gap(), -1);
    exp(4'h2, 18'h01002, 1'b0);
    exp(4'h3, 18'h12004, 1'b0);
    exp(4'h4, 18'h01002, 1'b0);
    exp(endk(6, 2, 1'b0), 18'h0, 1'b1);
    settle(0);
    foreach (na[j]) begin
      repeat (na[j]) SIDE.axle(gap(), -1);
      if (endk(na[j], 0, 1'b0) != 4'h0) exp(endk(na[j], 0, 1'b0), 18'h0, 1'b0);
      settle(0);
    end
    def_only <= 1'b1;
    SIDE.set(0, 1'b0, 50);
    repeat (4) SIDE.axle(gap(), -1);
    exp(4'h1, 18'h0, 1'b0);
    exp(4'h5, 18'h0, 1'b0);
    settle(0);
    SIDE.set(0, 1'b1, 500);
    chk("malf", 23'h1, {22'h0, malf[0]});
    repeat (1000) @(posedge clk);
    chk("malf", 23'h0, {22'h0, malf[0]});
    SIDE.set(9, 1'b1, 30);
    SIDE.set(4, 1'b0, 30);
    SIDE.set(4, 1'b1, 10);
    SIDE.set(4, 1'b0, 30);
    SIDE.set(4, 1'b1, 80);
    SIDE.set(4, 1'b0, 30);
    SIDE.set(4, 1'b1, 30);
    SIDE.set(9, 1'b0, 0);
    exp(4'h2, 18'h03000, 1'b0);
    exp(4'h3, 18'h03000, 1'b0);
    exp(4'h4, 18'h03000, 1'b0);
    exp(4'h4, 18'h03000, 1'b0);
    exp(4'h6, 18'h0, 1'b0);
    settle(1);
    mode <= 4'h8;
    SIDE.set(4, 1'b0, 5000);
    SIDE.set(4, 1'b1, 300);
    exp(4'h9, 18'h0, 1'b0);
    exp(4'h9, 18'h0, 1'b0);
    exp(4'ha, 18'h0, 1'b0);
    chk_q();
    complete_run();
  end
endmodule : ttam_top_tb
